//--- verilog/watchdog_timer_dev.sv
// watchdog timer device end: config unlock, indexed registers, countdown
// assumes single 100 MHz clk_in, io strobes synchronous one-cycle pulses
// How it works
// - expiry asserts system reset output
// - host reloads or stops before timeout
// - tick count is byte, 1 to 255
// - unit bit picks second or minute ticks
// - reload restores last programmed count
// - stop halts countdown, no reset
// - unlock key 87 01 55 55 required
// - index 02 data 02 relocks access
// - index port then data port access
// - keyboard interrupt reloads when enabled
// - config bit 7 set means seconds
// - config bit 6 enables reset output
// - nonzero count write loads and starts
// - zero count write stops watchdog
`timescale 1ns/10ps
`include "watchdog_timer_regs.svh"
module watchdog_timer_dev #(
  // cycles per second tick; a bench may shorten it to reach expiry
  parameter int unsigned SEC_CYCLES = `WD_SEC_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  watchdog_timer_if.device bus,
  input  wire logic       reload_in,
  output logic            sys_reset_out,
  output logic            expired_out,
  output logic            running_out
);
  watchdog_timer_pkg::unlock_state_t ul_q, ul_d;
  logic [7:0]  index_q, ldn_q, ctrl_q, cfg_q, init_q, remain_q;
  logic [7:0]  rdata_q;
  logic        rvalid_q, run_q, exp_q, kbd_q;
  logic [26:0] sec_cnt_q;
  logic [5:0]  min_cnt_q;

  // address decode
  wire idx_wr   = bus.io_wr && bus.io_addr == `WD_INDEX_PORT;
  wire dat_wr   = bus.io_wr && bus.io_addr == `WD_DATA_PORT;
  wire dat_rd   = bus.io_rd && bus.io_addr == `WD_DATA_PORT;
  wire is_open  = ul_q == watchdog_timer_pkg::OPEN;
  wire reg_wr   = dat_wr && is_open;
  wire cnt_wr   = reg_wr && index_q == `WD_COUNT_OFF;
  wire kbd_rise = bus.kbd_irq && !kbd_q;
  wire kbd_rel  = kbd_rise && ctrl_q[`WD_CTRL_KBD_BIT];
  wire reload   = (reload_in || kbd_rel) && run_q;
  wire sec_tick = sec_cnt_q == 27'(SEC_CYCLES - 1);
  wire min_wrap = min_cnt_q == 6'(`WD_SEC_PER_MIN - 1);
  // unit: bit set selects seconds, clear selects minutes
  wire tick     = sec_tick && (cfg_q[`WD_CFG_SEC_BIT] || min_wrap);
  wire [7:0] rd_mux =
    index_q == `WD_LDN_OFF   ? ldn_q :
    index_q == `WD_CTRL_OFF  ? ctrl_q :
    index_q == `WD_CFG_OFF   ? cfg_q :
    index_q == `WD_COUNT_OFF ? remain_q : 8'h00;

  // unlock sequencer; exit happens on index 02 then data 02
  always_comb begin
    ul_d = ul_q;
    if (idx_wr) begin
      unique case (ul_q)
        watchdog_timer_pkg::LOCKED:
          ul_d = bus.io_wdata == `WD_KEY0 ? watchdog_timer_pkg::GOT_K0 : ul_q;
        watchdog_timer_pkg::GOT_K0:
          ul_d = bus.io_wdata == `WD_KEY1 ? watchdog_timer_pkg::GOT_K1
                                          : watchdog_timer_pkg::LOCKED;
        watchdog_timer_pkg::GOT_K1:
          ul_d = bus.io_wdata == `WD_KEY2 ? watchdog_timer_pkg::GOT_K2
                                          : watchdog_timer_pkg::LOCKED;
        watchdog_timer_pkg::GOT_K2:
          ul_d = bus.io_wdata == `WD_KEY3 ? watchdog_timer_pkg::OPEN
                                          : watchdog_timer_pkg::LOCKED;
        watchdog_timer_pkg::OPEN: ul_d = ul_q;
        default: ul_d = watchdog_timer_pkg::LOCKED;
      endcase
    end else if (reg_wr && index_q == `WD_EXIT_INDEX &&
                 bus.io_wdata == `WD_EXIT_DATA) begin
      ul_d = watchdog_timer_pkg::LOCKED;
    end
  end

  // state and index registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ul_q    <= watchdog_timer_pkg::LOCKED;
      index_q <= `WD_RESET_VAL;
      kbd_q   <= 1'b0;
    end else begin
      ul_q    <= ul_d;
      kbd_q   <= bus.kbd_irq;
      if (idx_wr && is_open) index_q <= bus.io_wdata;
    end
  end

  // configuration registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ldn_q  <= `WD_RESET_VAL;
      ctrl_q <= `WD_RESET_VAL;
      cfg_q  <= `WD_RESET_VAL;
      init_q <= `WD_RESET_VAL;
    end else if (reg_wr) begin
      if (index_q == `WD_LDN_OFF)  ldn_q  <= bus.io_wdata;
      if (index_q == `WD_CTRL_OFF) ctrl_q <= bus.io_wdata;
      if (index_q == `WD_CFG_OFF)  cfg_q  <= bus.io_wdata;
      if (cnt_wr)                  init_q <= bus.io_wdata;
    end
  end

  // read answer one cycle after the data port read; locked reads give 00
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= dat_rd;
      if (dat_rd) rdata_q <= is_open ? rd_mux : 8'h00;
    end
  end

  // tick prescaler: a one-cycle enable each second, a minute count on top
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cnt_wr || reload) begin
      sec_cnt_q <= 27'h0000000;
      min_cnt_q <= 6'h00;
    end else if (run_q) begin
      sec_cnt_q <= sec_tick ? 27'h0000000 : sec_cnt_q + 27'h0000001;
      if (sec_tick) min_cnt_q <= min_wrap ? 6'h00 : min_cnt_q + 6'h01;
    end
  end

  // countdown; a write beats a reload, which beats a tick
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      remain_q <= `WD_RESET_VAL;
      run_q    <= 1'b0;
      exp_q    <= 1'b0;
    end else if (cnt_wr) begin
      remain_q <= bus.io_wdata;
      run_q    <= bus.io_wdata != 8'h00;
      exp_q    <= 1'b0;
    end else if (reload) begin
      remain_q <= init_q;
    end else if (run_q && tick) begin
      remain_q <= remain_q - 8'h01;
      if (remain_q == 8'h01) begin
        run_q <= 1'b0;
        exp_q <= 1'b1;
      end
    end
  end

  assign bus.io_rdata  = rdata_q;
  assign bus.io_rvalid = rvalid_q;
  assign expired_out   = exp_q;
  assign running_out   = run_q;
  // hardware reset only when enabled; stays until the count is rewritten
  assign sys_reset_out = exp_q && cfg_q[`WD_CFG_RST_BIT];
endmodule

//--- common/watchdog_timer_regs.svh
// watchdog timer constants: register offsets, fields, ports, unlock key
// assumes a 100 MHz clk_in; included by bare name
`ifndef WATCHDOG_TIMER_REGS_SVH
`define WATCHDOG_TIMER_REGS_SVH
`define WD_INDEX_PORT      16'h002E
`define WD_DATA_PORT       16'h002F
`define WD_KEY0            8'h87
`define WD_KEY1            8'h01
`define WD_KEY2            8'h55
`define WD_KEY3            8'h55
`define WD_EXIT_INDEX      8'h02
`define WD_EXIT_DATA       8'h02
`define WD_LDN_OFF         8'h07
`define WD_CTRL_OFF        8'h71
`define WD_CFG_OFF         8'h72
`define WD_COUNT_OFF       8'h73
`define WD_CTRL_KBD_BIT    5
`define WD_CFG_SEC_BIT     7
`define WD_CFG_RST_BIT     6
`define WD_RESET_VAL       8'h00
`define WD_CLK_HZ          100000000
`define WD_SEC_PER_MIN     60
`define WD_SEC_CYCLES      (`WD_CLK_HZ)
`endif

//--- common/watchdog_timer_pkg.sv
// watchdog timer types used by the device end
// no assumptions beyond a single clock
package watchdog_timer_pkg;
  // unlock progress, gray coded along the key sequence
  typedef enum logic [2:0] {
    LOCKED = 3'b000,
    GOT_K0 = 3'b001,
    GOT_K1 = 3'b011,
    GOT_K2 = 3'b010,
    OPEN   = 3'b110
  } unlock_state_t;
endpackage

//--- common/watchdog_timer_if.sv
// byte-wide i/o port link between host and watchdog device
// one i/o cycle per io_wr or io_rd pulse, answer one cycle later
`timescale 1ns/10ps
interface watchdog_timer_if;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_rdata;
  logic        io_rvalid;
  logic        kbd_irq;
  modport device (input io_addr, io_wdata, io_wr, io_rd, kbd_irq,
                  output io_rdata, io_rvalid);
  modport host (output io_addr, io_wdata, io_wr, io_rd, kbd_irq,
                input io_rdata, io_rvalid);
endinterface

//--- verilog/watchdog_timer_host.sv
// host end: turns user commands into index/data port cycles
// assumes the device answers reads one cycle after io_rd
`timescale 1ns/10ps
`include "watchdog_timer_regs.svh"
module watchdog_timer_host (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  watchdog_timer_if.host  bus,
  input  wire logic       cmd_valid_in,
  input  wire logic [1:0] cmd_kind_in,
  input  wire logic [7:0] cmd_data_in,
  input  wire logic       kbd_irq_in,
  output logic            cmd_ready_out,
  output logic [7:0]      rd_data_out,
  output logic            rd_valid_out
);
  // cmd_kind: 0 index write, 1 data write, 2 data read, 3 unused
  logic [15:0] addr_q;
  logic [7:0]  wdata_q, rd_q;
  logic        wr_q, rd_req_q, busy_q, rv_q;

  // one port cycle per command; busy while a read is outstanding
  wire take = cmd_valid_in && !busy_q && cmd_kind_in != 2'h3;
  wire is_idx = cmd_kind_in == 2'h0;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      addr_q   <= 16'h0000;
      wdata_q  <= 8'h00;
      wr_q     <= 1'b0;
      rd_req_q <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      wr_q     <= take && cmd_kind_in != 2'h2;
      rd_req_q <= take && cmd_kind_in == 2'h2;
      if (take) begin
        addr_q  <= is_idx ? `WD_INDEX_PORT : `WD_DATA_PORT;
        wdata_q <= cmd_data_in;
      end
      if (take && cmd_kind_in == 2'h2) busy_q <= 1'b1;
      else if (bus.io_rvalid) busy_q <= 1'b0;
    end
  end

  // capture the read answer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_q <= 8'h00;
      rv_q <= 1'b0;
    end else begin
      rv_q <= bus.io_rvalid;
      if (bus.io_rvalid) rd_q <= bus.io_rdata;
    end
  end

  assign bus.io_addr   = addr_q;
  assign bus.io_wdata  = wdata_q;
  assign bus.io_wr     = wr_q;
  assign bus.io_rd     = rd_req_q;
  assign bus.kbd_irq   = kbd_irq_in;
  assign cmd_ready_out = !busy_q;
  assign rd_data_out   = rd_q;
  assign rd_valid_out  = rv_q;
endmodule

//--- sim/watchdog_timer_assertions.sv
// checker: rules of the port link between the host and device ends
// assumes plain copies of the link signals and one clock domain
`timescale 1ns/10ps
module watchdog_timer_checker (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rvalid
);
  logic [2:0] key_q;
  logic [7:0] idx_q, ctl_q, cfg_q, cnt_q;
  // decode of the shadowed unlock state and the two ports
  wire open_w = key_q == 3'h4;
  wire idx_wr = io_wr && io_addr == 16'h002E;
  wire dat_wr = io_wr && io_addr == 16'h002F && open_w;
  wire [7:0] key_w = key_q == 3'h0 ? 8'h87 : key_q == 3'h1 ? 8'h01 : 8'h55;
  // shadow of what the device must hold; counts never rise above the written value, so <= is used
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      key_q <= 3'h0;
      idx_q <= 8'h00;
      ctl_q <= 8'h00;
      cfg_q <= 8'h00;
      cnt_q <= 8'h00;
    end else begin
      if (idx_wr && !open_w) key_q <= io_wdata == key_w ? key_q + 3'h1 : 3'h0;
      if (idx_wr && open_w) idx_q <= io_wdata;
      if (dat_wr && idx_q == 8'h02 && io_wdata == 8'h02) key_q <= 3'h0;
      if (dat_wr && idx_q == 8'h71) ctl_q <= io_wdata;
      if (dat_wr && idx_q == 8'h72) cfg_q <= io_wdata;
      if (dat_wr && idx_q == 8'h73) cnt_q <= io_wdata;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_rd_open(a);
    io_rd && io_addr == 16'h002F && open_w && idx_q == a;
  endsequence
  sequence s_exit;
    dat_wr && idx_q == 8'h02 && io_wdata == 8'h02;
  endsequence
  property p_rd_ans; io_rd |=> io_rvalid; endproperty
  property p_rv_cause; io_rvalid |-> $past(io_rd); endproperty
  property p_one_strobe; !(io_wr && io_rd); endproperty
  property p_locked;
    io_rd && io_addr == 16'h002F && !open_w |=> io_rdata == 8'h00;
  endproperty
  property p_relock;
    s_exit ##[1:8] (io_rd && io_addr == 16'h002F) |=> io_rdata == 8'h00;
  endproperty
  property p_ctl_rw;
    s_rd_open(8'h71) |=> io_rvalid && io_rdata == $past(ctl_q);
  endproperty
  property p_cfg_rw;
    s_rd_open(8'h72) |=> io_rvalid && io_rdata == $past(cfg_q);
  endproperty
  property p_cnt; s_rd_open(8'h73) |=> io_rdata <= $past(cnt_q); endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read got no answer");
  a_rv_cause: assert property (p_rv_cause)
    else $error("answer without read");
  a_one_strobe: assert property (p_one_strobe)
    else $error("read and write together");
  a_locked: assert property (p_locked)
    else $error("locked read not zero");
  a_relock: assert property (p_relock)
    else $error("read after exit not zero");
  a_ctl_rw: assert property (p_ctl_rw)
    else $error("control readback wrong");
  a_cfg_rw: assert property (p_cfg_rw)
    else $error("config readback wrong");
  a_cnt: assert property (p_cnt)
    else $error("count above written value");
endmodule

//--- sim/watchdog_timer_bench.sv
// bench: host end drives device end across the port link
// assumes 100 MHz clock; the device's second is cut to 100 cycles here
`timescale 1ns/10ps
module watchdog_timer_bench;
  logic       clk_in, rst_n_in, cmd_valid_in, kbd_irq_in, reload_in;
  logic [1:0] cmd_kind_in;
  logic [7:0] cmd_data_in, rd_data_out, got;
  logic       cmd_ready_out, rd_valid_out, sys_reset_out;
  logic       expired_out, running_out;
  int         n_mismatch = 0;
  int         checked = 0;
  watchdog_timer_if bus ();
  watchdog_timer_host u_watchdog_timer_host (.clk_in, .rst_n_in, .bus,
    .cmd_valid_in, .cmd_kind_in, .cmd_data_in, .kbd_irq_in, .cmd_ready_out,
    .rd_data_out, .rd_valid_out);
  watchdog_timer_dev #(.SEC_CYCLES(100)) u_watchdog_timer_dev (.clk_in,
    .rst_n_in, .bus, .reload_in, .sys_reset_out, .expired_out,
    .running_out);
  watchdog_timer_checker u_watchdog_timer_checker (.clk_in, .rst_n_in,
    .io_addr(bus.io_addr), .io_wdata(bus.io_wdata), .io_wr(bus.io_wr),
    .io_rd(bus.io_rd), .io_rdata(bus.io_rdata), .io_rvalid(bus.io_rvalid));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one host command; ready is looked at on the settled falling edge
  task automatic cmd(input logic [1:0] k, input logic [7:0] d);
    @(negedge clk_in);
    cmd_valid_in = 1'b1;
    cmd_kind_in = k;
    cmd_data_in = d;
    for (int i = 0; i < 8 && cmd_ready_out !== 1'b1; i++) @(negedge clk_in);
    @(posedge clk_in);
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cmd(2'h0, a);
    cmd(2'h1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    got = ~e;
    cmd(2'h0, a);
    cmd(2'h2, 8'h00);
    repeat (4) begin
      @(posedge clk_in);
      #1 if (rd_valid_out === 1'b1) got = rd_data_out;
    end
    chk(got, e);
  endtask
  task automatic key(input logic [7:0] last);
    cmd(2'h0, 8'h87);
    cmd(2'h0, 8'h01);
    cmd(2'h0, 8'h55);
    cmd(2'h0, last);
  endtask
  task automatic flags(input logic [7:0] e);
    repeat (3) @(negedge clk_in);
    chk({5'h00, running_out, expired_out, sys_reset_out}, e);
  endtask
  task automatic t_locked();
    wr(8'h72, 8'hC0);
    rd(8'h72, 8'h00);
    wr(8'h73, 8'h0A);
    flags(8'h00);
  endtask
  task automatic t_regs();
    key(8'h55);
    rd(8'h71, 8'h00);
    wr(8'h07, 8'h07);
    rd(8'h07, 8'h07);
    wr(8'h71, 8'h20);
    rd(8'h71, 8'h20);
    wr(8'h72, 8'hC0);
    rd(8'h72, 8'hC0);
  endtask
  // reload and keyboard pulses must leave the written count in place
  task automatic t_start();
    wr(8'h73, 8'h0A);
    flags(8'h04);
    rd(8'h73, 8'h0A);
    @(negedge clk_in) reload_in = 1'b1;
    @(negedge clk_in) reload_in = 1'b0;
    @(negedge clk_in) kbd_irq_in = 1'b1;
    @(negedge clk_in) kbd_irq_in = 1'b0;
    rd(8'h73, 8'h0A);
    flags(8'h04);
  endtask
  task automatic t_stop();
    wr(8'h73, 8'h00);
    flags(8'h00);
    rd(8'h73, 8'h00);
    wr(8'h73, 8'hFF);
    rd(8'h73, 8'hFF);
    wr(8'h73, 8'h01);
    rd(8'h73, 8'h01);
  endtask
  task automatic t_exit();
    wr(8'h02, 8'h02);
    rd(8'h72, 8'h00);
    wr(8'h73, 8'h00);
    flags(8'h04);
    key(8'hAA);
    rd(8'h72, 8'h00);
    key(8'h55);
    rd(8'h72, 8'hC0);
    wr(8'h73, 8'h00);
    flags(8'h00);
  endtask
  // expiry, reloads and stop, timed against the 100-cycle second
  task automatic t_expire();
    wr(8'h73, 8'h02);
    repeat (140) @(negedge clk_in);
    rd(8'h73, 8'h01);
    flags(8'h04);
    repeat (100) @(negedge clk_in);
    flags(8'h03);
    wr(8'h72, 8'h80);
    flags(8'h02);
    wr(8'h72, 8'hC0);
    wr(8'h73, 8'h02);
    repeat (140) @(negedge clk_in);
    @(negedge clk_in) reload_in = 1'b1;
    @(negedge clk_in) reload_in = 1'b0;
    rd(8'h73, 8'h02);
    repeat (100) @(negedge clk_in);
    @(negedge clk_in) kbd_irq_in = 1'b1;
    @(negedge clk_in) kbd_irq_in = 1'b0;
    rd(8'h73, 8'h02);
    // kind 3 must be ignored; taken as a data write it would stop the timer
    cmd(2'h3, 8'h00);
    flags(8'h04);
    wr(8'h73, 8'h00);
    repeat (300) @(negedge clk_in);
    flags(8'h00);
    wr(8'h72, 8'h40);
    wr(8'h73, 8'h01);
    repeat (300) @(negedge clk_in);
    rd(8'h73, 8'h01);
    flags(8'h04);
    repeat (6000) @(negedge clk_in);
    flags(8'h03);
    wr(8'h73, 8'h00);
    flags(8'h00);
  endtask
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    {rst_n_in, cmd_valid_in, kbd_irq_in, reload_in} = 4'h0;
    cmd_kind_in = 2'h0;
    cmd_data_in = 8'h00;
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_locked();
    t_regs();
    t_start();
    t_stop();
    t_exit();
    t_expire();
    wrap_up();
  end
  // the whole sequence needs about seven thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    wrap_up();
  end
endmodule
